// file: design/alarm_params.svh
// register map, field positions, reset values and alarm codes of the alarm checker
`ifndef ALARM_PARAMS_SVH
`define ALARM_PARAMS_SVH

// register byte addresses
`define ADDR_STATUS      8'h00
`define ADDR_CLEAR       8'h04
`define ADDR_ENABLE      8'h08
`define ADDR_ALARM       8'h0C
`define ADDR_CONTROL     8'h10
`define ADDR_REGEN_LIMIT 8'h14
`define ADDR_IN_BASE     8'h20
`define ADDR_IN_LAST     8'h3C
`define ADDR_OUT_ONE     8'h40
`define ADDR_OUT_TWO     8'h44

// field positions
`define ALARM_VALID_BIT  16
`define CTRL_CLEAR_BIT   0

// reset values
`define RST_ENABLE       12'h000
`define RST_REGEN_LIMIT  32'h0000_0000

// event bit positions
`define EV_CONTENTION    0
`define EV_POS_INIT      1
`define EV_REGEN         2
`define EV_ABS_OVF       3
`define EV_DEV_OVF       4
`define EV_SAFETY        5
`define EV_IN_DUP_LO     6
`define EV_IN_DUP_HI     7
`define EV_IN_NUM_LO     8
`define EV_IN_NUM_HI     9
`define EV_OUT_ONE       10
`define EV_OUT_TWO       11
`define EV_COUNT         12

// alarm main codes
`define MAIN_27          8'h1B
`define MAIN_28          8'h1C
`define MAIN_29          8'h1D
`define MAIN_30          8'h1E
`define MAIN_33          8'h21

// overflow limits, two's complement
`define ABS_POS_MAX      48'h0000_8000_0000
`define ABS_POS_MIN      48'hFFFF_8000_0000
`define DEV_MAX          40'h00_2000_0000
`define DEV_MIN          40'hFF_E000_0000

`endif

// file: design/alarm_pkg.sv
// types shared by the alarm checker modules
package alarm_pkg;

	typedef struct packed {
		logic [7:0] main_code;
		logic [7:0] sub_code;
	} alarm_code_t;

	// one general input assignment: two function slots and a logic setting
	typedef struct packed {
		logic [1:0] logic_sel;
		logic [7:0] func_b;
		logic [7:0] func_a;
	} pin_cfg_t;

endpackage

// file: design/pin_assign_check.sv
// per-pin checks of input and output function assignments
`timescale 1ns/100ps
module pin_assign_check
	import alarm_pkg::*;
#(
	parameter int         N_IN         = 8,
	parameter logic [7:0] MAX_IN_FUNC  = 8'h3F,
	parameter logic [7:0] MAX_OUT_FUNC = 8'h3F
) (
	// assignments
	input  pin_cfg_t   in_cfg  [N_IN],
	input  wire  [7:0] out_func [2],
	// results
	output logic [N_IN-1:0] in_dup,
	output logic [N_IN-1:0] in_bad,
	output logic [1:0]      out_bad
);

	genvar i;
	generate
		for (i = 0; i < N_IN; i++) begin : g_in
			// two different functions on one pin
			assign in_dup[i] = (in_cfg[i].func_a != 8'h00) &&
				(in_cfg[i].func_b != 8'h00) &&
				(in_cfg[i].func_a != in_cfg[i].func_b);
			// undefined number, or a logic setting other than a or b contact
			assign in_bad[i] = (in_cfg[i].func_a > MAX_IN_FUNC) ||
				(in_cfg[i].func_b > MAX_IN_FUNC) ||
				(in_cfg[i].logic_sel > 2'h1);
		end
		for (i = 0; i < 2; i++) begin : g_out
			assign out_bad[i] = out_func[i] > MAX_OUT_FUNC;
		end
	endgenerate

endmodule // pin_assign_check

// file: design/servo_protection_alarm_checker.sv
// protection alarm detection, alarm latch and register slave of a servo drive
`timescale 1ns/100ps
`include "alarm_params.svh"

// Behaviour
// - link up during analysis or test: 27/6
// - servo-on during position reset: 27/7
// - regen frequency over limit: 28/0
// - zero regen limit disables regen check
// - position deviation beyond 2^29: 29/2
// - either safety input off: 30/0
// - inputs one-four doubly assigned: 33/0
// - inputs five-eight doubly assigned: 33/1
// - inputs one-four bad number/logic: 33/2
// - inputs five-eight bad number/logic: 33/3
// - output one undefined number: 33/4
// - output two undefined number: 33/5
module servo_protection_alarm_checker
	import alarm_pkg::*;
#(
	parameter logic [7:0] MAX_IN_FUNC     = 8'h3F,
	parameter logic [7:0] MAX_OUT_FUNC    = 8'h3F,
	parameter logic       REGEN_CHECK_EN  = 1'b1,
	parameter logic       SAFETY_CHECK_EN = 1'b1
) (
	// clock, reset, enable
	input  wire  logic        CORE_CLK,
	input  wire  logic        SYS_RST,
	input  wire  logic        CLK_EN,
	// register port
	input  wire  logic [7:0]  REG_ADDR,
	input  wire  logic [31:0] REG_WDATA,
	input  wire  logic        REG_WR,
	input  wire  logic        REG_RD,
	output logic       [31:0] REG_RDATA,
	// host network and operation state
	input  wire  logic        NET_LINK_UP,
	input  wire  logic        FREQ_ANALYSIS_RUN,
	input  wire  logic        TEST_RUN_ACTIVE,
	input  wire  logic        SERVO_ON_REQ,
	input  wire  logic        POS_RESET_BUSY,
	// encoder and position path
	input  wire  logic [31:0] PULSE_REGEN_FREQ,
	input  wire  logic        ABS_MODE,
	input  wire  logic        POS_INIT_ACTIVE,
	input  wire  logic [47:0] ABS_POS_SCALED,
	input  wire  logic [39:0] POS_DEVIATION,
	// safety inputs, high when the photocoupler is on
	input  wire  logic        SAFETY_IN_ONE,
	input  wire  logic        SAFETY_IN_TWO,
	// alarm outputs
	output logic              ALARM_ACTIVE,
	output logic       [7:0]  ALARM_MAIN,
	output logic       [7:0]  ALARM_SUB,
	output logic              IRQ
);

	localparam int NEV = `EV_COUNT;

	// register state
	logic [NEV-1:0] status;
	logic [NEV-1:0] enable;
	logic [31:0]    pulse_regen_limit_setting;
	pin_cfg_t       in_cfg [8];
	logic [7:0]     out_func [2];
	logic           link_prev;
	alarm_code_t    latched;
	logic           alarm_valid;

	// next values
	logic [NEV-1:0] next_status;
	alarm_code_t    next_latched;
	logic           next_alarm_valid;
	logic [31:0]    rd_value;

	// address decode
	wire wr_clear   = REG_WR && (REG_ADDR == `ADDR_CLEAR);
	wire wr_enable  = REG_WR && (REG_ADDR == `ADDR_ENABLE);
	wire wr_control = REG_WR && (REG_ADDR == `ADDR_CONTROL);
	wire wr_limit   = REG_WR && (REG_ADDR == `ADDR_REGEN_LIMIT);
	wire in_range   = (REG_ADDR >= `ADDR_IN_BASE) &&
		(REG_ADDR <= `ADDR_IN_LAST) && (REG_ADDR[1:0] == 2'h0);
	wire wr_in      = REG_WR && in_range;
	wire [2:0] in_idx = REG_ADDR[4:2];
	wire wr_out_one = REG_WR && (REG_ADDR == `ADDR_OUT_ONE);
	wire wr_out_two = REG_WR && (REG_ADDR == `ADDR_OUT_TWO);
	wire alarm_clear = wr_control && REG_WDATA[`CTRL_CLEAR_BIT];

	// pin assignment checks
	logic [7:0] in_dup;
	logic [7:0] in_bad;
	logic [1:0] out_bad;

	pin_assign_check #(
		.N_IN         (8),
		.MAX_IN_FUNC  (MAX_IN_FUNC),
		.MAX_OUT_FUNC (MAX_OUT_FUNC)
	) u_pin_check (
		.in_cfg   (in_cfg),
		.out_func (out_func),
		.in_dup   (in_dup),
		.in_bad   (in_bad),
		.out_bad  (out_bad)
	);

	// detection conditions
	wire link_rise = NET_LINK_UP && !link_prev;
	wire standalone_run = FREQ_ANALYSIS_RUN || TEST_RUN_ACTIVE;
	wire ev_contention = link_rise && standalone_run;
	wire ev_pos_init = SERVO_ON_REQ && POS_RESET_BUSY;
	wire regen_armed = REGEN_CHECK_EN &&
		(pulse_regen_limit_setting != 32'h0000_0000);
	wire ev_regen = regen_armed &&
		(PULSE_REGEN_FREQ > pulse_regen_limit_setting);
	wire abs_out = ($signed(ABS_POS_SCALED) > $signed(`ABS_POS_MAX)) ||
		($signed(ABS_POS_SCALED) < $signed(`ABS_POS_MIN));
	wire ev_abs_ovf = ABS_MODE && POS_INIT_ACTIVE && abs_out;
	wire ev_dev_ovf = ($signed(POS_DEVIATION) > $signed(`DEV_MAX)) ||
		($signed(POS_DEVIATION) < $signed(`DEV_MIN));
	wire ev_safety = SAFETY_CHECK_EN &&
		!(SAFETY_IN_ONE && SAFETY_IN_TWO);

	wire [NEV-1:0] events = {
		out_bad[1],
		out_bad[0],
		|in_bad[7:4],
		|in_bad[3:0],
		|in_dup[7:4],
		|in_dup[3:0],
		ev_safety,
		ev_dev_ovf,
		ev_abs_ovf,
		ev_regen,
		ev_pos_init,
		ev_contention
	};

	// main and sub code of each event bit
	function automatic alarm_code_t code_of(input int idx);
		alarm_code_t c;
		c = '{8'h00, 8'h00};
		case (idx)
			`EV_CONTENTION: c = '{`MAIN_27, 8'h06};
			`EV_POS_INIT:   c = '{`MAIN_27, 8'h07};
			`EV_REGEN:      c = '{`MAIN_28, 8'h00};
			`EV_ABS_OVF:    c = '{`MAIN_29, 8'h01};
			`EV_DEV_OVF:    c = '{`MAIN_29, 8'h02};
			`EV_SAFETY:     c = '{`MAIN_30, 8'h00};
			`EV_IN_DUP_LO:  c = '{`MAIN_33, 8'h00};
			`EV_IN_DUP_HI:  c = '{`MAIN_33, 8'h01};
			`EV_IN_NUM_LO:  c = '{`MAIN_33, 8'h02};
			`EV_IN_NUM_HI:  c = '{`MAIN_33, 8'h03};
			`EV_OUT_ONE:    c = '{`MAIN_33, 8'h04};
			`EV_OUT_TWO:    c = '{`MAIN_33, 8'h05};
			default:        c = '{8'h00, 8'h00};
		endcase
		return c;
	endfunction

	// lowest event bit wins when several arrive together
	alarm_code_t first_code;
	always_comb begin
		first_code = '{8'h00, 8'h00};
		for (int k = NEV - 1; k >= 0; k--) begin
			if (events[k]) begin
				first_code = code_of(k);
			end
		end
	end

	// sticky status: a new event wins over a clear in the same cycle
	assign next_status = (status & ~(wr_clear ? REG_WDATA[NEV-1:0] :
		{NEV{1'b0}})) | events;

	// alarm latch: only the first alarm after a clear is kept
	always_comb begin
		next_latched     = latched;
		next_alarm_valid = alarm_valid;
		if ((!alarm_valid || alarm_clear) && (|events)) begin
			next_latched     = first_code;
			next_alarm_valid = 1'b1;
		end else if (alarm_clear) begin
			next_alarm_valid = 1'b0;
		end
	end

	// read selection
	always_comb begin
		rd_value = 32'h0000_0000;
		if (REG_ADDR == `ADDR_STATUS) begin
			rd_value[NEV-1:0] = status;
		end else if (REG_ADDR == `ADDR_ENABLE) begin
			rd_value[NEV-1:0] = enable;
		end else if (REG_ADDR == `ADDR_ALARM) begin
			rd_value[15:0] = {latched.sub_code, latched.main_code};
			rd_value[`ALARM_VALID_BIT] = alarm_valid;
		end else if (REG_ADDR == `ADDR_REGEN_LIMIT) begin
			rd_value = pulse_regen_limit_setting;
		end else if (in_range) begin
			rd_value[17:0] = in_cfg[in_idx];
		end else if (REG_ADDR == `ADDR_OUT_ONE) begin
			rd_value[7:0] = out_func[0];
		end else if (REG_ADDR == `ADDR_OUT_TWO) begin
			rd_value[7:0] = out_func[1];
		end
	end

	// status, enable, alarm latch and outputs
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			status       <= {NEV{1'b0}};
			enable       <= `RST_ENABLE;
			link_prev    <= 1'b0;
			latched      <= '{8'h00, 8'h00};
			alarm_valid  <= 1'b0;
			IRQ          <= 1'b0;
			REG_RDATA    <= 32'h0000_0000;
			ALARM_ACTIVE <= 1'b0;
			ALARM_MAIN   <= 8'h00;
			ALARM_SUB    <= 8'h00;
		end else if (CLK_EN) begin
			status       <= next_status;
			if (wr_enable) begin
				enable <= REG_WDATA[NEV-1:0];
			end
			link_prev    <= NET_LINK_UP;
			latched      <= next_latched;
			alarm_valid  <= next_alarm_valid;
			IRQ          <= |(next_status &
				(wr_enable ? REG_WDATA[NEV-1:0] : enable));
			REG_RDATA    <= REG_RD ? rd_value : 32'h0000_0000;
			ALARM_ACTIVE <= next_alarm_valid;
			ALARM_MAIN   <= next_latched.main_code;
			ALARM_SUB    <= next_latched.sub_code;
		end
	end

	// parameter registers
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			pulse_regen_limit_setting <= `RST_REGEN_LIMIT;
			for (int k = 0; k < 8; k++) begin
				in_cfg[k] <= '0;
			end
			out_func[0] <= 8'h00;
			out_func[1] <= 8'h00;
		end else if (CLK_EN) begin
			if (wr_limit) begin
				pulse_regen_limit_setting <= REG_WDATA;
			end
			if (wr_in) begin
				in_cfg[in_idx] <= REG_WDATA[17:0];
			end
			if (wr_out_one) begin
				out_func[0] <= REG_WDATA[7:0];
			end
			if (wr_out_two) begin
				out_func[1] <= REG_WDATA[7:0];
			end
		end
	end

endmodule // servo_protection_alarm_checker

// file: sim/alarm_checker_asserts.sv
// port assertions of the protection alarm checker
`timescale 1ns/100ps
module alarm_checker_asserts (
	// clock and reset
	input wire logic        CORE_CLK,
	input wire logic        SYS_RST,
	input wire logic        CLK_EN,
	// register port
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic [31:0] REG_RDATA,
	// conditions
	input wire logic        NET_LINK_UP,
	input wire logic        TEST_RUN_ACTIVE,
	input wire logic        FREQ_ANALYSIS_RUN,
	input wire logic        SERVO_ON_REQ,
	input wire logic        POS_RESET_BUSY,
	input wire logic        SAFETY_IN_ONE,
	input wire logic        SAFETY_IN_TWO,
	input wire logic [39:0] POS_DEVIATION,
	// alarm
	input wire logic        ALARM_ACTIVE,
	input wire logic [7:0]  ALARM_MAIN,
	input wire logic [7:0]  ALARM_SUB
);
	default clocking @(posedge CORE_CLK); endclocking
	// a frozen cycle proves nothing about the latch or the codes
	default disable iff (SYS_RST || !CLK_EN);
	a_link_code: assert property (!ALARM_ACTIVE && $rose(NET_LINK_UP) &&
		(TEST_RUN_ACTIVE || FREQ_ANALYSIS_RUN) |=>
		{ALARM_MAIN, ALARM_SUB} == 16'h1B06) else $error("contention code");
	a_servo_code: assert property (!ALARM_ACTIVE && SERVO_ON_REQ &&
		POS_RESET_BUSY && !$rose(NET_LINK_UP) |=>
		{ALARM_MAIN, ALARM_SUB} == 16'h1B07) else $error("servo-on code");
	a_safety_latch: assert property (!(SAFETY_IN_ONE && SAFETY_IN_TWO)
		|=> ALARM_ACTIVE) else $error("safety alarm missing");
	a_dev_latch: assert property (
		$signed(POS_DEVIATION) > 40'sh0020000000 ||
		$signed(POS_DEVIATION) < -40'sh0020000000 |=> ALARM_ACTIVE)
		else $error("deviation alarm missing");
	a_latch_hold: assert property (ALARM_ACTIVE && !REG_WR |=>
		ALARM_ACTIVE && $stable({ALARM_MAIN, ALARM_SUB}))
		else $error("latched alarm changed");
	a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
		else $error("read data outside slot");
	a_main_set: assert property (ALARM_ACTIVE |-> ALARM_MAIN inside
		{8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h21}) else $error("bad main code");
	a_pin_sub: assert property (ALARM_ACTIVE && ALARM_MAIN == 8'h21
		|-> ALARM_SUB <= 8'h05) else $error("bad pin sub code");
	cover property ($rose(ALARM_ACTIVE));
	cover property (ALARM_MAIN == 8'h21 && ALARM_SUB == 8'h05);
	cover property ($fell(ALARM_ACTIVE));
endmodule // alarm_checker_asserts
bind servo_protection_alarm_checker alarm_checker_asserts chk (.*);

// file: sim/host_side_model.sv
// host link, operation state and safety input model
`timescale 1ns/100ps
module host_side_model (
	// clock and command
	input  wire logic       clk,
	input  wire logic [2:0] cmd,
	// levels toward the drive
	output logic            link_up,
	output logic            freq_run,
	output logic            test_run,
	output logic            servo_on,
	output logic            pos_busy,
	output logic            safe_one,
	output logic            safe_two
);
	// levels change only just after an edge
	always_ff @(posedge clk) begin
		link_up  <= cmd == 3'h1 || cmd == 3'h2;
		freq_run <= cmd == 3'h1;
		test_run <= cmd == 3'h2;
		servo_on <= cmd == 3'h3;
		pos_busy <= cmd == 3'h3;
		safe_one <= cmd != 3'h4;
		safe_two <= cmd != 3'h5;
	end
endmodule // host_side_model

// file: sim/servo_protection_alarm_checker_test.sv
// self-checking bench of the protection alarm checker
`timescale 1ns/100ps
`include "alarm_params.svh"
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin \
	n_mismatch++; $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module servo_protection_alarm_checker_test;
	logic CORE_CLK = 0, SYS_RST = 1, REG_WR = 0, REG_RD = 0, ABS_MODE = 0;
	logic CLK_EN = 1;
	logic POS_INIT_ACTIVE = 0, link, frun, trun, son, pbusy, s1, s2;
	logic [7:0] REG_ADDR = 0, ALARM_MAIN, ALARM_SUB;
	logic [31:0] REG_WDATA = 0, REG_RDATA, PULSE_REGEN_FREQ = 0, lim;
	logic [47:0] ABS_POS_SCALED = 0;
	logic [39:0] POS_DEVIATION = 0;
	logic [2:0] cmd = 0;
	logic ALARM_ACTIVE, IRQ, rd_q = 0, alm_q = 0;
	logic [31:0] q[$];
	int n_mismatch = 0, n_compared = 0, seed = 54;
	logic [15:0] ecode[16] = '{16'h1B06, 16'h1B06, 16'h1B07, 16'h1C00,
		16'h1D01, 16'h1D01, 16'h1D02, 16'h1D02, 16'h1E00, 16'h1E00,
		16'h2100, 16'h2101, 16'h2102, 16'h2103, 16'h2104, 16'h2105};
	int ebit[16] = '{0, 0, 1, 2, 3, 3, 4, 4, 5, 5, 6, 7, 8, 9, 10, 11};
	servo_protection_alarm_checker uut (.CLK_EN(CLK_EN), .NET_LINK_UP(link),
		.FREQ_ANALYSIS_RUN(frun), .TEST_RUN_ACTIVE(trun), .SERVO_ON_REQ(son),
		.POS_RESET_BUSY(pbusy), .SAFETY_IN_ONE(s1), .SAFETY_IN_TWO(s2), .*);
	host_side_model far (.clk(CORE_CLK), .cmd(cmd), .link_up(link),
		.freq_run(frun), .test_run(trun), .servo_on(son), .pos_busy(pbusy),
		.safe_one(s1), .safe_two(s2));
	initial forever #5 CORE_CLK = ~CORE_CLK;
	task print_verdict;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		REG_ADDR <= a; REG_WDATA <= d; REG_WR <= 1'b1;
		@(posedge CORE_CLK); REG_WR <= 1'b0; @(posedge CORE_CLK);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back(e); REG_ADDR <= a; REG_RD <= 1'b1;
		@(posedge CORE_CLK); REG_RD <= 1'b0; @(posedge CORE_CLK);
	endtask
	task apply(input int i, input logic on);
		case (i)
			0, 1, 2: cmd <= on ? 3'(i + 1) : 3'h0;
			8, 9: cmd <= on ? 3'(i - 4) : 3'h0;
			3: PULSE_REGEN_FREQ <= on ? lim + 1 + ($random(seed) & 'hFF) : 0;
			4, 5: begin
				ABS_MODE <= on; POS_INIT_ACTIVE <= on;
				ABS_POS_SCALED <= !on ? 48'h0 : i == 4 ? 48'h0000_8000_0001
					: 48'hFFFF_7FFF_FFFF;
			end
			6, 7: POS_DEVIATION <= !on ? 40'h0 : i == 6 ? 40'h00_2000_0001
				: 40'hFF_DFFF_FFFF;
			10: wr(8'h2C, on ? 32'h0201 : 0);
			11: wr(8'h30, on ? 32'h0201 : 0);
			12: wr(8'h20, on ? 32'h0040 : 0);
			13: wr(8'h3C, on ? 32'h20000 : 0);
			14: wr(8'h40, on ? 32'h0040 : 0);
			default: wr(8'h44, on ? 32'h0040 : 0);
		endcase
	endtask
	task clear_all;
		repeat (3) @(posedge CORE_CLK);
		wr(`ADDR_CONTROL, 1); wr(`ADDR_CLEAR, 32'hFFF);
		rd(`ADDR_STATUS, 0);
	endtask
	always @(posedge CORE_CLK) begin
		if (rd_q) `CHK("rdata", q.pop_front(), REG_RDATA)
		if (ALARM_ACTIVE && !alm_q)
			`CHK("alarm", q.pop_front(), {16'h0, ALARM_MAIN, ALARM_SUB})
		rd_q <= REG_RD; alm_q <= ALARM_ACTIVE;
	end
	initial begin
		repeat (20000) @(posedge CORE_CLK);
		n_mismatch++; print_verdict;
	end
	initial begin
		repeat (20) @(posedge CORE_CLK);
		SYS_RST <= 1'b0; @(posedge CORE_CLK);
		lim = ($random(seed) & 32'hFFFF) + 1;
		wr(`ADDR_REGEN_LIMIT, lim);
		for (int i = 0; i < 16; i++) begin
			wr(`ADDR_ENABLE, i % 2 ? 0 : 1 << ebit[i]);
			q.push_back({16'h0, ecode[i]});
			apply(i, 1);
			repeat (4) @(posedge CORE_CLK);
			`CHK("irq", ~i[0], IRQ)
			rd(`ADDR_ALARM, {15'h0, 1'b1, ecode[i][7:0], ecode[i][15:8]});
			rd(`ADDR_STATUS, 1 << ebit[i]);
			apply(i, 0);
			clear_all;
			`CHK("irq off", 1'b0, IRQ)
			`CHK("alarm off", 1'b0, ALARM_ACTIVE)
			$display("test %0d done", i);
		end
		q.push_back(32'h2102);
		apply(12, 1); apply(6, 1); repeat (3) @(posedge CORE_CLK);
		rd(`ADDR_ALARM, 32'h1_0221);
		rd(`ADDR_STATUS, 32'h110);
		apply(12, 0); apply(6, 0); clear_all;
		wr(`ADDR_REGEN_LIMIT, 0);
		PULSE_REGEN_FREQ <= 32'hFFFF_FFFF;
		POS_DEVIATION <= 40'h00_2000_0000;
		repeat (4) @(posedge CORE_CLK);
		rd(`ADDR_STATUS, 0);
		rd(`ADDR_REGEN_LIMIT, 0);
		CLK_EN <= 1'b0;
		wr(`ADDR_REGEN_LIMIT, 32'h5);
		CLK_EN <= 1'b1;
		rd(`ADDR_REGEN_LIMIT, 0);
		rd(8'h18, 0);
		$display("test boundary done");
		print_verdict;
	end
endmodule // servo_protection_alarm_checker_test
